// [logic/servo_input_device_command_handler.sv]
// APB-driven interpreter for input-device on/off, test words and keyed I/O disable.
//
// What this block does
// - Device state is the last received word ORed with the synchronised external pins.
// - Word [6][0] bit 0 drives servo enable.
// - Word [6][0] bits 4-27 map listed devices.
// - Bits 1,2 stroke limits; 11,12 start.
// - Word [6][1] bits 24-31 are point selects.
// - Data is the hexadecimal bit-mapped value.
// - Input disable independent of device on/off.
// - Disabled inputs read as off.
// - Emergency stop and limits never disabled.
// - Keyed [0][0]/[1][0] disables/enables inputs.
// - Keyed [0][3]/[1][3] disables/enables outputs.
// - Test mode accepts words [0][0],[0][1].
// - Read [8][0],[8][1] returns output statuses.
`timescale 1ns/10ps
`include "servo_cmd_defines.svh"

module servo_input_device_command_handler (
	input  wire logic                          core_clk_in,
	input  wire logic                          rstn_in,
	input  wire logic                          psel_in,
	input  wire logic                          penable_in,
	input  wire logic                          pwrite_in,
	input  wire logic [7:0]                    paddr_in,
	input  wire logic [31:0]                   pwdata_in,
	input  wire logic [3:0]                    pstrb_in,
	output logic      [31:0]                   prdata_out,
	output logic                               pready_out,
	output logic                               pslverr_out,
	input  wire logic                          test_mode_in,
	input  wire logic [31:0]                   ext_word0_in,
	input  wire logic [31:0]                   ext_word1_in,
	input  wire logic                          emergency_stop_in,
	input  wire logic [31:0]                   out_dev0_raw_in,
	input  wire logic [31:0]                   out_dev1_raw_in,
	output servo_cmd_pkg::dev_word0_type       input_devices0_out,
	output servo_cmd_pkg::dev_word1_type       input_devices1_out,
	output logic                               emergency_stop_out,
	output logic                               analog_pulse_en_out,
	output logic      [31:0]                   out_dev0_out,
	output logic      [31:0]                   out_dev1_out
);

	// Register state.
	logic [15:0] cmd_ff;
	logic [15:0] nxt_cmd;
	logic [31:0] word0_ff;
	logic [31:0] nxt_word0;
	logic [31:0] word1_ff;
	logic [31:0] nxt_word1;
	logic [31:0] reply_ff;
	logic [31:0] nxt_reply;
	logic        in_dis_ff;
	logic        nxt_in_dis;
	logic        out_dis_ff;
	logic        nxt_out_dis;
	logic        err_ff;
	logic        nxt_err;

	// Bus answer state.
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic        pready_ff;
	logic        nxt_pready;
	logic        pslverr_ff;
	logic        nxt_pslverr;

	// Pin synchronisers and device outputs.
	logic [31:0] ext0_meta_ff;
	logic [31:0] ext0_sync_ff;
	logic [31:0] ext1_meta_ff;
	logic [31:0] ext1_sync_ff;
	logic        stop_meta_ff;
	logic        stop_sync_ff;
	logic [31:0] eff0_ff;
	logic [31:0] nxt_eff0;
	logic [31:0] eff1_ff;
	logic [31:0] nxt_eff1;
	logic        stop_out_ff;
	logic        ana_en_ff;
	logic [31:0] odev0_ff;
	logic [31:0] nxt_odev0;
	logic [31:0] odev1_ff;
	logic [31:0] nxt_odev1;

	// Decoded bus strobes and command fields.
	logic        setup_ph;
	logic        access_done;
	logic        wr_cmd;
	logic        wr_data;
	logic        wr_status;
	logic        mapped;
	logic [7:0]  cmd_code;
	logic [7:0]  cmd_dno;
	logic [7:0]  new_code;
	logic [7:0]  new_dno;
	logic        key_ok;

	// Strobes: a write takes effect at the access edge on which pready is high.
	always_comb begin
		setup_ph    = psel_in & ~penable_in;
		access_done = psel_in & penable_in & pready_ff;
		wr_cmd      = access_done & pwrite_in & (paddr_in == `CMD_REG_OFFS);
		wr_data     = access_done & pwrite_in & (paddr_in == `DATA_REG_OFFS);
		wr_status   = access_done & pwrite_in & (paddr_in == `STATUS_REG_OFFS);
		cmd_code    = cmd_ff[`CMD_CODE_MSB:`CMD_CODE_LSB];
		cmd_dno     = cmd_ff[`CMD_DNO_MSB:`CMD_DNO_LSB];
		new_code    = pwdata_in[`CMD_CODE_MSB:`CMD_CODE_LSB];
		new_dno     = pwdata_in[`CMD_DNO_MSB:`CMD_DNO_LSB];
		key_ok      = (pwdata_in == `IO_KEY_WORD);
		mapped      = (paddr_in[1:0] == 2'h0) & (paddr_in <= `EFF1_REG_OFFS);
	end

	// Command execution: device words, keyed disables, status reads and the error flag.
	always_comb begin
		nxt_cmd     = cmd_ff;
		nxt_word0   = word0_ff;
		nxt_word1   = word1_ff;
		nxt_reply   = reply_ff;
		nxt_in_dis  = in_dis_ff;
		nxt_out_dis = out_dis_ff;
		nxt_err     = err_ff;
		if (wr_status && pwdata_in[`STAT_ERR_BIT]) begin
			nxt_err = 1'b0;
		end
		if (wr_cmd) begin
			nxt_cmd = pwdata_in[15:0];
			if (new_code == `CMD_STATUS_READ) begin
				if (new_dno == `DNO_OUT_STAT0) begin
					nxt_reply = out_dev0_raw_in;
				end else if (new_dno == `DNO_OUT_STAT1) begin
					nxt_reply = out_dev1_raw_in;
				end else begin
					nxt_err = 1'b1;
				end
			end
		end
		if (wr_data) begin
			unique case (cmd_code)
				`CMD_DEV_SET: begin
					// The whole word replaces the earlier one; absent bits turn off.
					if (cmd_dno == `DNO_WORD0) begin
						nxt_word0 = pwdata_in;
					end else if (cmd_dno == `DNO_WORD1) begin
						nxt_word1 = pwdata_in;
					end else if (test_mode_in && cmd_dno == `DNO_TEST_WORD0) begin
						nxt_word0 = pwdata_in;
					end else if (test_mode_in && cmd_dno == `DNO_TEST_WORD1) begin
						nxt_word1 = pwdata_in;
					end else begin
						nxt_err = 1'b1;
					end
				end
				`CMD_IO_DISABLE: begin
					// Disable state moves only with the key; device words stay as they are.
					if (!key_ok) begin
						nxt_err = 1'b1;
					end else if (cmd_dno == `DNO_IN_DISABLE) begin
						nxt_in_dis = 1'b1;
					end else if (cmd_dno == `DNO_IN_ENABLE) begin
						nxt_in_dis = 1'b0;
					end else if (cmd_dno == `DNO_OUT_DISABLE) begin
						nxt_out_dis = 1'b1;
					end else if (cmd_dno == `DNO_OUT_ENABLE) begin
						nxt_out_dis = 1'b0;
					end else begin
						nxt_err = 1'b1;
					end
				end
				default: begin
					nxt_err = 1'b1;
				end
			endcase
		end
	end

	// Command state registers.
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			cmd_ff     <= `CMD_RST;
			word0_ff   <= `WORD_RST;
			word1_ff   <= `WORD_RST;
			reply_ff   <= `WORD_RST;
			in_dis_ff  <= 1'b0;
			out_dis_ff <= 1'b0;
			err_ff     <= 1'b0;
		end else begin
			cmd_ff     <= nxt_cmd;
			word0_ff   <= nxt_word0;
			word1_ff   <= nxt_word1;
			reply_ff   <= nxt_reply;
			in_dis_ff  <= nxt_in_dis;
			out_dis_ff <= nxt_out_dis;
			err_ff     <= nxt_err;
		end
	end

	// Read data and error are prepared in the setup cycle so the access phase needs no wait.
	always_comb begin
		nxt_pready  = setup_ph;
		nxt_pslverr = setup_ph & ~mapped;
		nxt_prdata  = prdata_ff;
		if (setup_ph) begin
			nxt_prdata = 32'h00000000;
			if (!pwrite_in) begin
				unique case (paddr_in)
					`CMD_REG_OFFS:    nxt_prdata = {16'h0000, cmd_ff};
					`WORD0_REG_OFFS:  nxt_prdata = word0_ff;
					`WORD1_REG_OFFS:  nxt_prdata = word1_ff;
					`STATUS_REG_OFFS: nxt_prdata = {28'h0000000, err_ff, test_mode_in,
					                                out_dis_ff, in_dis_ff};
					`REPLY_REG_OFFS:  nxt_prdata = reply_ff;
					`EFF0_REG_OFFS:   nxt_prdata = eff0_ff;
					`EFF1_REG_OFFS:   nxt_prdata = eff1_ff;
					default:          nxt_prdata = 32'h00000000;
				endcase
			end
		end
	end

	// Bus answer registers.
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			prdata_ff  <= 32'h00000000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	// Effective devices: commanded or external, masked by the disables.
	always_comb begin
		nxt_eff0  = word0_ff | ext0_sync_ff;
		nxt_eff1  = word1_ff | ext1_sync_ff;
		nxt_odev0 = out_dis_ff ? 32'h00000000 : out_dev0_raw_in;
		nxt_odev1 = out_dis_ff ? 32'h00000000 : out_dev1_raw_in;
		if (in_dis_ff) begin
			nxt_eff0 = nxt_eff0 & `PROTECT_MASK0;
			nxt_eff1 = 32'h00000000;
		end
	end

	// Pin synchronisers and device output registers.
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			ext0_meta_ff <= 32'h00000000;
			ext0_sync_ff <= 32'h00000000;
			ext1_meta_ff <= 32'h00000000;
			ext1_sync_ff <= 32'h00000000;
			stop_meta_ff <= 1'b0;
			stop_sync_ff <= 1'b0;
			eff0_ff      <= 32'h00000000;
			eff1_ff      <= 32'h00000000;
			stop_out_ff  <= 1'b0;
			ana_en_ff    <= 1'b0;
			odev0_ff     <= 32'h00000000;
			odev1_ff     <= 32'h00000000;
		end else begin
			ext0_meta_ff <= ext_word0_in;
			ext0_sync_ff <= ext0_meta_ff;
			ext1_meta_ff <= ext_word1_in;
			ext1_sync_ff <= ext1_meta_ff;
			stop_meta_ff <= emergency_stop_in;
			stop_sync_ff <= stop_meta_ff;
			eff0_ff      <= nxt_eff0;
			eff1_ff      <= nxt_eff1;
			stop_out_ff  <= stop_sync_ff;
			ana_en_ff    <= ~in_dis_ff;
			odev0_ff     <= nxt_odev0;
			odev1_ff     <= nxt_odev1;
		end
	end

	// Output wiring from flip-flops.
	assign prdata_out          = prdata_ff;
	assign pready_out          = pready_ff;
	assign pslverr_out         = pslverr_ff;
	assign input_devices0_out  = servo_cmd_pkg::dev_word0_type'(eff0_ff);
	assign input_devices1_out  = servo_cmd_pkg::dev_word1_type'(eff1_ff);
	assign emergency_stop_out  = stop_out_ff;
	assign analog_pulse_en_out = ana_en_ff;
	assign out_dev0_out        = odev0_ff;
	assign out_dev1_out        = odev1_ff;

	// Checks on command effects and masking.
	a_word0_replace: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		wr_data && cmd_code == `CMD_DEV_SET && cmd_dno == `DNO_WORD0
		|=> word0_ff == $past(pwdata_in))
		else $error("First device word not replaced by data write.");

	a_servo_enable: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		wr_data && cmd_code == `CMD_DEV_SET && cmd_dno == `DNO_WORD0 && !in_dis_ff
		|=> ##1 input_devices0_out.servo_enable_in
		== ($past(pwdata_in[0], 2) | $past(ext0_sync_ff[0])))
		else $error("Servo enable does not follow bit 0.");

	a_point_select: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		wr_data && cmd_code == `CMD_DEV_SET && cmd_dno == `DNO_WORD1
		|=> word1_ff[31:24] == $past(pwdata_in[31:24]))
		else $error("Point select bits not taken from second word.");

	a_test_gate: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		wr_data && !test_mode_in && cmd_code == `CMD_DEV_SET
		&& cmd_dno == `DNO_TEST_WORD0 |=> $stable(word0_ff) && err_ff)
		else $error("Test word accepted outside test operation.");

	a_disable_indep: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		wr_data && cmd_code == `CMD_IO_DISABLE |=> $stable(word0_ff) && $stable(word1_ff))
		else $error("Disable command altered device words.");

	a_inputs_off: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		in_dis_ff |=> (eff0_ff & ~`PROTECT_MASK0) == 32'h00000000 && eff1_ff == 32'h00000000)
		else $error("Disabled input device still on.");

	a_limits_kept: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		in_dis_ff |=> eff0_ff[2:1] == $past(word0_ff[2:1] | ext0_sync_ff[2:1]))
		else $error("Stroke limit lost under input disable.");

	a_key_disable: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		wr_data && cmd_code == `CMD_IO_DISABLE && key_ok && cmd_dno == `DNO_IN_DISABLE
		|=> in_dis_ff ##1 !analog_pulse_en_out)
		else $error("Keyed input disable not applied.");

	a_out_disable: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		out_dis_ff |=> out_dev0_out == 32'h00000000 && out_dev1_out == 32'h00000000)
		else $error("Output devices driven while disabled.");

	a_status_read: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		wr_cmd && new_code == `CMD_STATUS_READ && new_dno == `DNO_OUT_STAT1
		|=> reply_ff == $past(out_dev1_raw_in))
		else $error("Output status reply wrong.");

	a_bad_key: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		wr_data && cmd_code == `CMD_IO_DISABLE && !key_ok
		|=> $stable(in_dis_ff) && $stable(out_dis_ff) && err_ff)
		else $error("Unkeyed command changed disable state.");

endmodule : servo_input_device_command_handler

// [logic/servo_cmd_defines.svh]
// Offsets, field positions, key word and command codes of the servo input-device command handler.
`ifndef SERVO_CMD_DEFINES_SVH
`define SERVO_CMD_DEFINES_SVH

// APB byte offsets, one aligned 32-bit word each.
`define CMD_REG_OFFS      8'h00
`define DATA_REG_OFFS     8'h04
`define WORD0_REG_OFFS    8'h08
`define WORD1_REG_OFFS    8'h0C
`define STATUS_REG_OFFS   8'h10
`define REPLY_REG_OFFS    8'h14
`define EFF0_REG_OFFS     8'h18
`define EFF1_REG_OFFS     8'h1C

// Command register fields.
`define CMD_CODE_MSB      15
`define CMD_CODE_LSB      8
`define CMD_DNO_MSB       7
`define CMD_DNO_LSB       0

// Status register bit positions.
`define STAT_IN_DIS_BIT   0
`define STAT_OUT_DIS_BIT  1
`define STAT_TEST_BIT     2
`define STAT_ERR_BIT      3

// Command codes and data numbers.
`define CMD_DEV_SET       8'h92
`define CMD_IO_DISABLE    8'h90
`define CMD_STATUS_READ   8'h12
`define DNO_WORD0         8'h60
`define DNO_WORD1         8'h61
`define DNO_TEST_WORD0    8'h00
`define DNO_TEST_WORD1    8'h01
`define DNO_IN_DISABLE    8'h00
`define DNO_IN_ENABLE     8'h10
`define DNO_OUT_DISABLE   8'h03
`define DNO_OUT_ENABLE    8'h13
`define DNO_OUT_STAT0     8'h80
`define DNO_OUT_STAT1     8'h81

// Key word that disable and enable commands must carry.
`define IO_KEY_WORD       32'h00001EA5

// Input bits that survive an input disable (both stroke-end limits).
`define PROTECT_MASK0     32'h00000006

// Reset values.
`define WORD_RST          32'h00000000
`define CMD_RST           16'h0000

`endif

// [logic/servo_cmd_pkg.sv]
// Packed layouts of the two input-device words.
package servo_cmd_pkg;

	// First input-device word, bit 31 down to bit 0.
	typedef struct packed {
		logic [3:0] rsv_31_28;
		logic       gain_change;
		logic [1:0] rsv_26_25;
		logic       pause_resume;
		logic       override_sel;
		logic [3:0] rsv_22_19;
		logic       proximity_dog;
		logic       auto_manual_sel;
		logic [3:0] rsv_16_13;
		logic       rev_start;
		logic       fwd_start;
		logic [2:0] rsv_10_8;
		logic       clear_in;
		logic       alarm_reset_in;
		logic       proportional_ctrl;
		logic       internal_torque_limit_sel;
		logic       rsv_3;
		logic       rev_stroke_limit;
		logic       fwd_stroke_limit;
		logic       servo_enable_in;
	} dev_word0_type;

	// Second input-device word, point-table selects in the top byte.
	typedef struct packed {
		logic        point_sel_8;
		logic        point_sel_7;
		logic        point_sel_6;
		logic        point_sel_5;
		logic        point_sel_4;
		logic        point_sel_3;
		logic        point_sel_2;
		logic        point_sel_1;
		logic [23:0] rsv_23_0;
	} dev_word1_type;

endpackage : servo_cmd_pkg

// [dv/host_master_model.sv]
// Host master station model that issues APB transfers to the command handler.
`timescale 1ns/10ps
module host_master_model (
	input  wire logic        clk_in,
	input  wire logic        pready_in,
	input  wire logic [31:0] prdata_in,
	input  wire logic        pslverr_in,
	output logic             psel_out,
	output logic             penable_out,
	output logic             pwrite_out,
	output logic [7:0]       paddr_out,
	output logic [31:0]      pwdata_out,
	output logic [3:0]       pstrb_out
);
	// The bus starts idle with select, enable, write, address and data low and all four byte strobes high.
	initial begin
		psel_out    = 1'b0;
		penable_out = 1'b0;
		pwrite_out  = 1'b0;
		paddr_out   = 8'h00;
		pwdata_out  = 32'h00000000;
		pstrb_out   = 4'hF;
	end

	// One transfer: setup, then access held until pready is seen high at an edge.
	// The wait has no limit of its own; the bench watchdog ends a hang.
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
		output logic [31:0] rdata, output logic err);
		@(posedge clk_in);
		psel_out    <= 1'b1;
		penable_out <= 1'b0;
		pwrite_out  <= wr;
		paddr_out   <= addr;
		pwdata_out  <= data;
		@(posedge clk_in);
		penable_out <= 1'b1;
		do begin
			@(posedge clk_in);
		end while (pready_in !== 1'b1);
		rdata = prdata_in;
		err = pslverr_in;
		psel_out    <= 1'b0;
		penable_out <= 1'b0;
		pwdata_out  <= ~data; // Released data does not keep its last value.
	endtask : xfer
endmodule : host_master_model

// [dv/tb_servo_input_device_command_handler.sv]
// Self-checking testbench for the servo input-device command handler.
`timescale 1ns/10ps
`include "servo_cmd_defines.svh"
module tb_servo_input_device_command_handler;
	typedef struct {
		logic [7:0]  dno;
		logic [31:0] data;
		logic [31:0] exp0;
		logic [31:0] exp1;
	} row_type;
	logic        core_clk_in, rstn_in, psel, penable, pwrite, pready, pslverr;
	logic        test_mode, estop_pin, estop, apen;
	logic [7:0]  paddr;
	logic [3:0]  pstrb;
	logic [31:0] pwdata, prdata, ext0, ext1, raw0, raw1, odev0, odev1, rdum;
	logic        edum;
	servo_cmd_pkg::dev_word0_type eff0;
	servo_cmd_pkg::dev_word1_type eff1;
	int          errors;
	int          cmp_count;
	row_type     rows [6] = '{
		'{8'h60, 32'h00000001, 32'h00000001, 32'h00000000},
		'{8'h60, 32'h00000006, 32'h00000006, 32'h00000000},
		'{8'h60, 32'h000018F0, 32'h000018F0, 32'h00000000},
		'{8'h60, 32'h09860001, 32'h09860001, 32'h00000000},
		'{8'h61, 32'hFF000000, 32'h09860001, 32'hFF000000},
		'{8'h60, 32'h00000000, 32'h00000000, 32'hFF000000}};

	// The clock toggles every half period of 5 ns.
	always #5 core_clk_in = ~core_clk_in;

	servo_input_device_command_handler i_dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .test_mode_in(test_mode), .ext_word0_in(ext0),
		.ext_word1_in(ext1), .emergency_stop_in(estop_pin), .out_dev0_raw_in(raw0),
		.out_dev1_raw_in(raw1), .input_devices0_out(eff0), .input_devices1_out(eff1),
		.emergency_stop_out(estop), .analog_pulse_en_out(apen), .out_dev0_out(odev0),
		.out_dev1_out(odev1));

	host_master_model i_host (.clk_in(core_clk_in), .pready_in(pready), .prdata_in(prdata),
		.pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
		.paddr_out(paddr), .pwdata_out(pwdata), .pstrb_out(pstrb));

	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Register access helpers; every access must finish without a slave error.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_host.xfer(1'b1, a, d, rdum, edum);
		chk(32'(edum), 32'h0);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		i_host.xfer(1'b0, a, 32'h0, rdum, edum);
		chk(32'(edum), 32'h0);
		chk(rdum, exp);
	endtask : rd
	task automatic cmd(input logic [7:0] code, input logic [7:0] dno, input logic [31:0] d);
		wr(`CMD_REG_OFFS, {16'h0000, code, dno});
		wr(`DATA_REG_OFFS, d);
	endtask : cmd
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask : settle

	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test

	// A hang is cut short well after the expected run length.
	initial begin
		repeat (20000) @(posedge core_clk_in);
		errors++;
		finish_test();
	end

	// Main sequence: reset, table of word writes, then the awkward cases.
	initial begin
		core_clk_in = 1'b0;
		rstn_in = 1'b0;
		test_mode = 1'b0;
		estop_pin = 1'b0;
		ext0 = 32'h0;
		ext1 = 32'h0;
		raw0 = 32'hA5A50001;
		raw1 = 32'h0F000000;
		errors = 0;
		cmp_count = 0;
		repeat (10) @(posedge core_clk_in);
		rstn_in <= 1'b1;
		rd(`WORD0_REG_OFFS, 32'h0);
		rd(`STATUS_REG_OFFS, 32'h0);
		foreach (rows[i]) begin
			cmd(`CMD_DEV_SET, rows[i].dno, rows[i].data);
			settle(3);
			chk(eff0, rows[i].exp0);
			chk(eff1, rows[i].exp1);
			chk(32'(eff1.point_sel_1), 32'(rows[i].exp1[24]));
		end
		@(posedge core_clk_in);
		ext0 <= 32'h00000010;
		ext1 <= 32'h00800000;
		settle(5);
		chk(eff0, 32'h00000010);
		chk(eff1, 32'hFF800000);
		@(posedge core_clk_in);
		ext0 <= 32'h0;
		cmd(`CMD_DEV_SET, `DNO_WORD0, 32'h00001807);
		cmd(`CMD_IO_DISABLE, `DNO_IN_DISABLE, `IO_KEY_WORD);
		settle(3);
		chk(eff0, 32'h00000006);
		chk(eff1, 32'h0);
		chk(32'(apen), 32'h0);
		rd(`STATUS_REG_OFFS, 32'h1);
		estop_pin <= 1'b1;
		settle(4);
		chk(32'(estop), 32'h1);
		cmd(`CMD_DEV_SET, `DNO_WORD0, 32'h00001801);
		settle(3);
		chk(eff0, 32'h0);
		rd(`WORD0_REG_OFFS, 32'h00001801);
		cmd(`CMD_IO_DISABLE, `DNO_IN_ENABLE, 32'h00001EA4);
		rd(`STATUS_REG_OFFS, 32'h9);
		wr(`STATUS_REG_OFFS, 32'h8);
		cmd(`CMD_IO_DISABLE, `DNO_IN_ENABLE, `IO_KEY_WORD);
		settle(3);
		chk(eff0, 32'h00001801);
		chk(32'(apen), 32'h1);
		chk(odev0, raw0);
		cmd(`CMD_IO_DISABLE, `DNO_OUT_DISABLE, `IO_KEY_WORD);
		settle(3);
		chk(odev0, 32'h0);
		chk(odev1, 32'h0);
		rd(`STATUS_REG_OFFS, 32'h2);
		cmd(`CMD_IO_DISABLE, `DNO_OUT_ENABLE, `IO_KEY_WORD);
		settle(3);
		chk(odev1, raw1);
		wr(`CMD_REG_OFFS, {16'h0000, `CMD_STATUS_READ, `DNO_OUT_STAT0});
		rd(`REPLY_REG_OFFS, raw0);
		wr(`CMD_REG_OFFS, {16'h0000, `CMD_STATUS_READ, `DNO_OUT_STAT1});
		rd(`REPLY_REG_OFFS, raw1);
		cmd(`CMD_DEV_SET, `DNO_TEST_WORD0, 32'h00000011);
		rd(`STATUS_REG_OFFS, 32'h8);
		rd(`WORD0_REG_OFFS, 32'h00001801);
		wr(`STATUS_REG_OFFS, 32'h8);
		test_mode <= 1'b1;
		cmd(`CMD_DEV_SET, `DNO_TEST_WORD0, 32'h00000011);
		cmd(`CMD_DEV_SET, `DNO_TEST_WORD1, 32'h01000000);
		settle(3);
		chk(eff0, 32'h00000011);
		chk(eff1, 32'h01800000);
		rd(`STATUS_REG_OFFS, 32'h4);
		rd(`EFF0_REG_OFFS, 32'h00000011);
		rd(`EFF1_REG_OFFS, 32'h01800000);
		rd(`CMD_REG_OFFS, 32'h00009201);
		rd(`DATA_REG_OFFS, 32'h0);
		i_host.xfer(1'b0, 8'h20, 32'h0, rdum, edum);
		chk(32'(edum), 32'h1);
		i_host.xfer(1'b1, 8'h02, 32'h0, rdum, edum);
		chk(32'(edum), 32'h1);
		rstn_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		rstn_in <= 1'b1;
		settle(1);
		chk(eff0, 32'h0);
		rd(`WORD0_REG_OFFS, 32'h0);
		finish_test();
	end
endmodule : tb_servo_input_device_command_handler
